// ==== apts_pkg.sv ====
// Constants shared by the position transfer supervisor
package apts_pkg;
  // Clock and reference tick
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
  // Sequencing delays in milliseconds, tick is one millisecond
  localparam int unsigned TICK_MS = TICK_US / 1000;
  localparam int unsigned BASE_DELAY_MS = 95;
  localparam int unsigned FS_BASE_DELAY_MS = 210;
  localparam int unsigned FS_READY_DELAY_MS = 5;
  localparam int unsigned MODE_LIMIT_MS = 5000;
  localparam int unsigned REQ_ON_LIMIT_MS = 1000;
  localparam int unsigned REQ_OFF_LIMIT_MS = 1000;
  localparam logic [15:0] BASE_TICKS = 16'(BASE_DELAY_MS / TICK_MS);
  localparam logic [15:0] FS_BASE_TICKS = 16'(FS_BASE_DELAY_MS / TICK_MS);
  localparam logic [15:0] FS_READY_TICKS = 16'(FS_READY_DELAY_MS / TICK_MS);
  localparam logic [15:0] MODE_TICKS = 16'(MODE_LIMIT_MS / TICK_MS);
  localparam logic [15:0] REQ_ON_TICKS = 16'(REQ_ON_LIMIT_MS / TICK_MS);
  localparam logic [15:0] REQ_OFF_TICKS = 16'(REQ_OFF_LIMIT_MS / TICK_MS);
  // Register byte offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] REPLY_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] POSCMD_OFS = 8'h0C;
  localparam logic [7:0] STATION_OFS = 8'h10;
  // Command register fields
  localparam int CMD_LSB = 0;
  localparam int DNO_LSB = 8;
  localparam int STN_LSB = 16;
  localparam logic [7:0] READ_POS_CMD = 8'h02;
  localparam logic [7:0] READ_POS_DNO = 8'h91;
  // Status register fields
  localparam int ST_VALID = 0;
  localparam int ST_ERR = 1;
  localparam int ST_BASE = 2;
  localparam int ST_READY = 3;
  localparam int ST_WARN = 4;
  // Error code returned in place of position data
  localparam logic [31:0] REPLY_ERR_CODE = 32'h0000_00E1;
  localparam logic [7:0] STATION_RST = 8'h00;
  // Timer indices
  localparam int NTIM = 6;
  localparam int T_BASE = 0;
  localparam int T_FSBASE = 1;
  localparam int T_FSRDY = 2;
  localparam int T_MODE = 3;
  localparam int T_REQON = 4;
  localparam int T_REQOFF = 5;
  typedef enum logic [2:0] {
    SEQ_OFF     = 3'b000,
    SEQ_WBASE   = 3'b001,
    SEQ_BASE_ON = 3'b010,
    SEQ_FS_WAIT = 3'b011,
    SEQ_FS_RDY  = 3'b100,
    SEQ_READY   = 3'b101
  } apts_seq_t;
endpackage : apts_pkg

// ==== apts_timer.sv ====
// Tick-counting interval timer with registered expiry flag
`timescale 1ns/1ps
`default_nettype none
module apts_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             tick,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] limit,
  // Result
  output logic                  expired
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic             exp_reg;
  logic             exp_next;

  initial
  begin
    if (WIDTH < 2) $error("apts_timer WIDTH too small");
  end

  always_comb
  begin
    cnt_next = '0;
    if (run && tick && cnt_reg != limit)
      cnt_next = cnt_reg + 1'b1;
    else if (run)
      cnt_next = cnt_reg;
    exp_next = run && (cnt_reg == limit);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      exp_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign expired = exp_reg;
endmodule : apts_timer
`default_nettype wire

// ==== apts_supervisor.sv ====
// Absolute position transfer supervisor, amplifier side
//
// Functional notes
// R1 - Controller flags error when data-ready stays low one second or more.
// R2 - Controller flags error when transfer mode lasts over five seconds.
// R3 - Controller flags error when position request stays on over one second.
// R4 - Amplifier raises time-out warning on request on, off or mode overrun.
// R5 - Controller comm error clears only when servo-on switch goes low.
// R6 - Checksum error clears on servo-on switch rise or fall by type.
// R7 - Servo alarm indication clears by alarm reset or power cycle.
// R8 - Master reads position with command 02, data number 91, right station.
// R9 - Amplifier replies with 32-bit position in command pulse units.
// R10 - Controller reads position every time servo-on is asserted.
// R11 - Response time-out supervision during serial read lives in controller.
// R12 - Read command returns position and loads it as position command.
// R13 - Base circuit turns on 95 ms after servo-on.
// R14 - Drive ready asserts only after base circuit is on.
// R15 - Controller withholds pulses until ready and position obtained.
// R16 - On communication fault amplifier returns error code instead of data.
// R17 - Controller retries failed reads, then enters error handling.
// R18 - On fault output controller drops servo-on and repeats acquisition.
// R19 - After forced stop release base on 210 ms later, ready 5 ms more.
// R20 - Controller acquires position between ready rise and first command.
// R21 - Controller raises checksum error after four consecutive mismatches; model counts four in total, cleared only on servo-on rise.
// R22 - Intervals are counted from a reference tick of settable period.
`timescale 1ns/1ps
`default_nettype none
module apts_supervisor #(
  parameter int unsigned TICK_CYCLES = apts_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Servo control inputs
  input  wire logic        servo_on_request,
  input  wire logic        emergency_stop_input,
  input  wire logic        fault_active,
  input  wire logic [31:0] current_position,
  // Transfer handshake inputs
  input  wire logic        xfer_mode,
  input  wire logic        position_request,
  // Status outputs
  output logic             base_circuit_on,
  output logic             drive_ready,
  output logic             transfer_timeout_warning
);
  localparam int TW = $clog2(TICK_CYCLES);

  initial
  begin
    if (TICK_CYCLES < 2) $error("TICK_CYCLES must be at least 2");
  end

  // Reference tick
  logic [TW-1:0]     tdiv_reg;
  logic [TW-1:0]     tdiv_next;
  logic              tick_reg;
  logic              tick_next;

  always_comb
  begin
    tick_next = (tdiv_reg == TW'(TICK_CYCLES - 1)); // R22
    tdiv_next = tick_next ? '0 : tdiv_reg + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdiv_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tdiv_reg <= tdiv_next;
      tick_reg <= tick_next;
    end
  end

  // Interval timers
  apts_pkg::apts_seq_t state_reg;
  apts_pkg::apts_seq_t state_next;
  logic [apts_pkg::NTIM-1:0] t_run;
  logic [apts_pkg::NTIM-1:0] t_exp;
  logic [15:0]               t_lim [apts_pkg::NTIM];

  always_comb
  begin
    t_lim[apts_pkg::T_BASE]   = apts_pkg::BASE_TICKS;
    t_lim[apts_pkg::T_FSBASE] = apts_pkg::FS_BASE_TICKS;
    t_lim[apts_pkg::T_FSRDY]  = apts_pkg::FS_READY_TICKS;
    t_lim[apts_pkg::T_MODE]   = apts_pkg::MODE_TICKS;
    t_lim[apts_pkg::T_REQON]  = apts_pkg::REQ_ON_TICKS;
    t_lim[apts_pkg::T_REQOFF] = apts_pkg::REQ_OFF_TICKS;
    t_run[apts_pkg::T_BASE]   = state_reg == apts_pkg::SEQ_WBASE;
    t_run[apts_pkg::T_FSBASE] = state_reg == apts_pkg::SEQ_FS_WAIT;
    t_run[apts_pkg::T_FSRDY]  = state_reg == apts_pkg::SEQ_FS_RDY;
    t_run[apts_pkg::T_MODE]   = xfer_mode;
    t_run[apts_pkg::T_REQON]  = xfer_mode && position_request;
    t_run[apts_pkg::T_REQOFF] = xfer_mode && !position_request;
  end

  for (genvar i = 0; i < apts_pkg::NTIM; i++)
  begin : g_tim
    apts_timer #(.WIDTH(16)) u_tim (
      .clk     (clk),
      .rst_n   (rst_n),
      .tick    (tick_reg),
      .run     (t_run[i]),
      .limit   (t_lim[i]),
      .expired (t_exp[i])
    );
  end

  // Servo-on sequencing
  logic fs_seen_reg;
  logic fs_seen_next;
  logic enable_ok;

  always_comb
  begin
    enable_ok = servo_on_request && !emergency_stop_input && !fault_active;
    state_next = state_reg;
    fs_seen_next = fs_seen_reg | emergency_stop_input;
    case (state_reg)
      apts_pkg::SEQ_OFF:
        if (enable_ok)
          state_next = fs_seen_reg ? apts_pkg::SEQ_FS_WAIT
                                   : apts_pkg::SEQ_WBASE;
      apts_pkg::SEQ_WBASE:
        if (t_exp[apts_pkg::T_BASE])
          state_next = apts_pkg::SEQ_BASE_ON; // R13
      apts_pkg::SEQ_BASE_ON:
        state_next = apts_pkg::SEQ_READY; // R14
      apts_pkg::SEQ_FS_WAIT:
        if (t_exp[apts_pkg::T_FSBASE])
          state_next = apts_pkg::SEQ_FS_RDY; // R19
      apts_pkg::SEQ_FS_RDY:
        if (t_exp[apts_pkg::T_FSRDY])
          state_next = apts_pkg::SEQ_READY; // R19
      apts_pkg::SEQ_READY:
        fs_seen_next = emergency_stop_input;
      default:
        state_next = apts_pkg::SEQ_OFF;
    endcase
    if (!enable_ok)
      state_next = apts_pkg::SEQ_OFF;
    if (state_next == apts_pkg::SEQ_READY)
      fs_seen_next = 1'b0;
  end

  logic base_reg;
  logic base_next;
  logic rdy_reg;
  logic rdy_next;

  always_comb
  begin
    base_next = state_next == apts_pkg::SEQ_BASE_ON ||
                state_next == apts_pkg::SEQ_FS_RDY ||
                state_next == apts_pkg::SEQ_READY;
    rdy_next = state_next == apts_pkg::SEQ_READY && base_reg; // R14
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg   <= apts_pkg::SEQ_OFF;
      fs_seen_reg <= 1'b0;
      base_reg    <= 1'b0;
      rdy_reg     <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      fs_seen_reg <= fs_seen_next;
      base_reg    <= base_next;
      rdy_reg     <= rdy_next;
    end
  end

  // APB slave, serial read command and warning
  logic        acc;
  logic        cmd_wr;
  logic        cmd_ok;
  logic        warn_set;
  logic        rdy_out_reg;
  logic        rdy_out_next;
  logic        err_out_reg;
  logic        err_out_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] reply_reg;
  logic [31:0] reply_next;
  logic [31:0] poscmd_reg;
  logic [31:0] poscmd_next;
  logic [7:0]  stn_reg;
  logic [7:0]  stn_next;
  logic        valid_reg;
  logic        valid_next;
  logic        rerr_reg;
  logic        rerr_next;
  logic        warn_reg;
  logic        warn_next;
  logic        mapped;

  always_comb
  begin
    acc = psel && penable && !rdy_out_reg;
    cmd_wr = acc && pwrite && paddr == apts_pkg::CMD_OFS;
    cmd_ok = pwdata[apts_pkg::CMD_LSB +: 8] == apts_pkg::READ_POS_CMD &&
             pwdata[apts_pkg::DNO_LSB +: 8] == apts_pkg::READ_POS_DNO;
    mapped = paddr == apts_pkg::CMD_OFS || paddr == apts_pkg::REPLY_OFS ||
             paddr == apts_pkg::STATUS_OFS ||
             paddr == apts_pkg::POSCMD_OFS ||
             paddr == apts_pkg::STATION_OFS;
    rdy_out_next = acc;
    err_out_next = acc && !mapped;
    reply_next = reply_reg;
    poscmd_next = poscmd_reg;
    valid_next = valid_reg;
    rerr_next = rerr_reg;
    stn_next = stn_reg;
    if (cmd_wr && pwdata[apts_pkg::STN_LSB +: 8] == stn_reg)
    begin
      valid_next = 1'b1;
      rerr_next = !cmd_ok;
      if (cmd_ok)
      begin
        reply_next = current_position; // R9
        poscmd_next = current_position; // R12
      end
      else
        reply_next = apts_pkg::REPLY_ERR_CODE; // R16
    end
    if (acc && pwrite && paddr == apts_pkg::STATION_OFS)
      stn_next = pwdata[7:0];
    warn_set = t_exp[apts_pkg::T_MODE] || t_exp[apts_pkg::T_REQON] ||
               t_exp[apts_pkg::T_REQOFF];
    warn_next = warn_reg;
    if (acc && pwrite && paddr == apts_pkg::STATUS_OFS &&
        pwdata[apts_pkg::ST_WARN])
      warn_next = 1'b0;
    if (warn_set)
      warn_next = 1'b1; // R4
    rdata_next = '0;
    if (acc && !pwrite)
      case (paddr)
        apts_pkg::REPLY_OFS:   rdata_next = reply_reg;
        apts_pkg::POSCMD_OFS:  rdata_next = poscmd_reg;
        apts_pkg::STATION_OFS: rdata_next = {24'h000000, stn_reg};
        apts_pkg::STATUS_OFS:
        begin
          rdata_next[apts_pkg::ST_VALID] = valid_reg;
          rdata_next[apts_pkg::ST_ERR]   = rerr_reg;
          rdata_next[apts_pkg::ST_BASE]  = base_reg;
          rdata_next[apts_pkg::ST_READY] = rdy_reg;
          rdata_next[apts_pkg::ST_WARN]  = warn_reg;
        end
        default:               rdata_next = '0;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdy_out_reg <= 1'b0;
      err_out_reg <= 1'b0;
      rdata_reg   <= '0;
      reply_reg   <= '0;
      poscmd_reg  <= '0;
      stn_reg     <= apts_pkg::STATION_RST;
      valid_reg   <= 1'b0;
      rerr_reg    <= 1'b0;
      warn_reg    <= 1'b0;
    end
    else
    begin
      rdy_out_reg <= rdy_out_next;
      err_out_reg <= err_out_next;
      rdata_reg   <= rdata_next;
      reply_reg   <= reply_next;
      poscmd_reg  <= poscmd_next;
      stn_reg     <= stn_next;
      valid_reg   <= valid_next;
      rerr_reg    <= rerr_next;
      warn_reg    <= warn_next;
    end
  end

  assign prdata = rdata_reg;
  assign pready = rdy_out_reg;
  assign pslverr = err_out_reg;
  assign base_circuit_on = base_reg;
  assign drive_ready = rdy_reg;
  assign transfer_timeout_warning = warn_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ready_needs_base_a: assert property (rdy_reg |-> base_reg) // R14
    else $error("ready without base circuit");
  base_after_wait_a: assert property ($rose(base_reg) &&
      $past(state_reg) == apts_pkg::SEQ_WBASE
      |-> $past(t_exp[apts_pkg::T_BASE])) // R13
    else $error("base on before delay");
  ready_follows_base_a: assert property (
      state_reg == apts_pkg::SEQ_BASE_ON && enable_ok |=> rdy_reg) // R14
    else $error("ready did not follow base");
  fs_ready_delay_a: assert property ($rose(rdy_reg) &&
      $past(state_reg) == apts_pkg::SEQ_FS_RDY
      |-> $past(t_exp[apts_pkg::T_FSRDY])) // R19
    else $error("ready before forced stop delay");
  estop_drops_base_a: assert property (
      emergency_stop_input |=> !base_reg && !rdy_reg) // R19
    else $error("base stays on in forced stop");
  warn_on_timeout_a: assert property (warn_set |=> warn_reg) // R4
    else $error("timeout warning lost");
  reply_loads_cmd_a: assert property (cmd_wr && cmd_ok &&
      pwdata[apts_pkg::STN_LSB +: 8] == stn_reg
      |=> poscmd_reg == reply_reg && valid_reg && !rerr_reg) // R12
    else $error("position command not loaded");
  error_code_reply_a: assert property (cmd_wr && !cmd_ok &&
      pwdata[apts_pkg::STN_LSB +: 8] == stn_reg
      |=> reply_reg == apts_pkg::REPLY_ERR_CODE && rerr_reg) // R16
    else $error("error code not returned");
  apb_one_wait_a: assert property (psel && penable && !pready
      |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  seq_ready_c: cover property ($rose(rdy_reg));
  fs_path_c: cover property (state_reg == apts_pkg::SEQ_FS_RDY);
  good_read_c: cover property (cmd_wr && cmd_ok);
  warn_c: cover property ($rose(warn_reg));
endmodule : apts_supervisor
`default_nettype wire

// ==== apts_ctrl_model.sv ====
// Controller-side model driving the transfer handshake
`timescale 1ns/1ps
`default_nettype none
module apts_ctrl_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench commands
  input  wire logic servo_cmd,
  input  wire logic mode_cmd,
  input  wire logic req_cmd,
  input  wire logic alarm_reset_cmd,
  input  wire logic sum_bad_cmd,
  // Amplifier side
  input  wire logic fault_active,
  input  wire logic transfer_timeout_warning,
  output logic      servo_on_request,
  output logic      xfer_mode,
  output logic      position_request,
  output logic      comm_error,
  output logic      alarm_coil_a,
  output logic      checksum_error_coil_a
);
  logic       comm_next;
  logic       alarm_next;
  logic       chk_next;
  logic [2:0] sum_cnt_reg;
  logic [2:0] sum_cnt_next;
  logic       son_d_reg;
  // Servo-on dropped while the fault output stands
  assign servo_on_request = servo_cmd & ~fault_active;
  assign xfer_mode        = mode_cmd;
  assign position_request = mode_cmd & req_cmd;
  always_comb
  begin
    comm_next = comm_error | transfer_timeout_warning;
    if (!servo_on_request)
    begin
      comm_next = 1'b0;
    end
    alarm_next = fault_active | (alarm_coil_a & ~alarm_reset_cmd);
    sum_cnt_next = sum_cnt_reg;
    if (sum_bad_cmd && sum_cnt_reg != 3'h4)
      sum_cnt_next = sum_cnt_reg + 3'h1;
    chk_next = checksum_error_coil_a | (sum_cnt_reg == 3'h4);
    if (servo_on_request && !son_d_reg)
    begin
      chk_next = 1'b0;
      sum_cnt_next = 3'h0;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_coil_a          <= 1'b0;
      checksum_error_coil_a <= 1'b0;
      sum_cnt_reg           <= 3'h0;
      son_d_reg             <= 1'b0;
    end
    else
    begin
      alarm_coil_a          <= alarm_next;
      checksum_error_coil_a <= chk_next;
      sum_cnt_reg           <= sum_cnt_next;
      son_d_reg             <= servo_on_request;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comm_error <= 1'b0;
    end
    else
    begin
      comm_error <= comm_next;
    end
  end
endmodule : apts_ctrl_model
`default_nettype wire

// ==== apts_supervisor_bench.sv ====
// Self-checking bench for the position transfer supervisor
`timescale 1ns/1ps
`default_nettype none
module apts_supervisor_bench;
  localparam int T = 4;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pos;
  logic servo_cmd, mode_cmd, req_cmd, estop, fault;
  logic servo_on_request, xfer_mode, position_request, comm_error;
  logic alarm_reset_cmd, sum_bad_cmd, alarm_coil_a, checksum_error_coil_a;
  logic base_circuit_on, drive_ready, transfer_timeout_warning;
  int   err_count, compares, n;

  apts_supervisor #(.TICK_CYCLES(T)) i_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .servo_on_request(servo_on_request), .emergency_stop_input(estop),
    .fault_active(fault), .current_position(pos),
    .xfer_mode(xfer_mode), .position_request(position_request),
    .base_circuit_on(base_circuit_on), .drive_ready(drive_ready),
    .transfer_timeout_warning(transfer_timeout_warning));

  apts_ctrl_model i_ctrl (
    .clk(clk), .rst_n(rst_n), .servo_cmd(servo_cmd),
    .mode_cmd(mode_cmd), .req_cmd(req_cmd), .fault_active(fault),
    .alarm_reset_cmd(alarm_reset_cmd), .sum_bad_cmd(sum_bad_cmd),
    .alarm_coil_a(alarm_coil_a),
    .checksum_error_coil_a(checksum_error_coil_a),
    .transfer_timeout_warning(transfer_timeout_warning),
    .servo_on_request(servo_on_request), .xfer_mode(xfer_mode),
    .position_request(position_request), .comm_error(comm_error));

  always #2.5 clk = ~clk;

  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic expire(input string nm);
    err_count++;
    $display("BAD %s expected event seen none", nm);
    print_verdict();
  endtask : expire

  // One APB transfer, then an idle cycle
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int i;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
      expire("pready");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
    check("wr_err", {31'h0, er}, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, exp,
                    input string nm);
    logic [31:0] d;
    logic        er;
    apb(1'b0, a, 32'h0, d, er);
    check(nm, d & m, exp);
  endtask : rd

  // Waits for base (0), ready (1) or warning (2) and checks the delay
  task automatic wait_in(input int sel, lo, hi, input string nm);
    logic v;
    for (n = 1; n <= hi + 8; n++)
    begin
      @(posedge clk);
      v = sel == 0 ? base_circuit_on : sel == 1 ? drive_ready
        : transfer_timeout_warning;
      if (v === 1'b1)
        break;
    end
    if (n > hi + 8)
      expire(nm);
    check(nm, 32'(n >= lo && n <= hi), 32'h1);
  endtask : wait_in

  task automatic clear_warn();
    mode_cmd <= 1'b0;
    req_cmd  <= 1'b0;
    wr(apts_pkg::STATUS_OFS, 32'h1 << apts_pkg::ST_WARN);
    rd(apts_pkg::STATUS_OFS, 32'h10, 32'h0, "warn_clr");
  endtask : clear_warn

  function automatic logic [31:0] cmd(input logic [7:0] s, dno);
    return {8'h00, s, dno, apts_pkg::READ_POS_CMD};
  endfunction : cmd

  initial
  begin
    clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; pos = 32'h1234_5678;
    servo_cmd = 0; mode_cmd = 0; req_cmd = 0; estop = 0; fault = 0;
    alarm_reset_cmd = 0; sum_bad_cmd = 0;
    err_count = 0; compares = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("base_rst", {31'h0, base_circuit_on}, 32'h0);
    rd(apts_pkg::STATUS_OFS, 32'hFFFF_FFFF, 32'h0, "status_rst");
    rd(apts_pkg::STATION_OFS, 32'hFF, 32'h0, "station_rst");
    wr(apts_pkg::STATION_OFS, 32'h5);
    rd(apts_pkg::STATION_OFS, 32'hFF, 32'h5, "station");
    wr(apts_pkg::CMD_OFS, cmd(8'h05, apts_pkg::READ_POS_DNO));
    rd(apts_pkg::REPLY_OFS, '1, 32'h1234_5678, "reply");
    rd(apts_pkg::POSCMD_OFS, '1, 32'h1234_5678, "poscmd");
    rd(apts_pkg::STATUS_OFS, 32'h3, 32'h1, "st_ok");
    wr(apts_pkg::REPLY_OFS, 32'h0);
    rd(apts_pkg::REPLY_OFS, '1, 32'h1234_5678, "reply_ro");
    pos <= 32'h0BAD_F00D;
    wr(apts_pkg::CMD_OFS, cmd(8'h03, apts_pkg::READ_POS_DNO));
    rd(apts_pkg::REPLY_OFS, '1, 32'h1234_5678, "other_stn");
    wr(apts_pkg::CMD_OFS, cmd(8'h05, 8'h90));
    rd(apts_pkg::REPLY_OFS, '1, apts_pkg::REPLY_ERR_CODE, "err");
    rd(apts_pkg::STATUS_OFS, 32'h3, 32'h3, "st_err");
    rd(apts_pkg::POSCMD_OFS, '1, 32'h1234_5678, "poscmd_kept");
    rd(8'h14, '1, 32'h0, "unmapped");
    servo_cmd <= 1'b1;
    wait_in(0, 94 * T, 96 * T + 4, "base_dly");
    check("rdy_early", {31'h0, drive_ready}, 32'h0);
    wait_in(1, 1, 3, "rdy_dly");
    wr(apts_pkg::CMD_OFS, cmd(8'h05, apts_pkg::READ_POS_DNO));
    rd(apts_pkg::POSCMD_OFS, '1, 32'h0BAD_F00D, "pos_on");
    mode_cmd <= 1'b1;
    req_cmd  <= 1'b1;
    wait_in(2, 999 * T, 1001 * T + 4, "req_on");
    @(posedge clk);
    check("comm", {31'h0, comm_error}, 32'h1);
    clear_warn();
    mode_cmd <= 1'b1;
    wait_in(2, 999 * T, 1001 * T + 4, "req_off");
    clear_warn();
    mode_cmd <= 1'b1;
    repeat (12)
    begin
      req_cmd <= ~req_cmd;
      repeat (400 * T) @(posedge clk);
    end
    check("mode_early", {31'h0, transfer_timeout_warning}, 32'h0);
    wait_in(2, 198 * T, 202 * T + 4, "mode");
    clear_warn();
    estop <= 1'b1;
    repeat (3) @(posedge clk);
    check("fs_base", {31'h0, base_circuit_on}, 32'h0);
    check("fs_rdy", {31'h0, drive_ready}, 32'h0);
    estop <= 1'b0;
    wait_in(0, 209 * T, 211 * T + 4, "fs_base_dly");
    wait_in(1, 4 * T, 6 * T + 4, "fs_rdy_dly");
    rd(apts_pkg::STATUS_OFS, 32'hC, 32'hC, "st_rdy");
    pos <= 32'h0000_0F5A;
    wr(apts_pkg::CMD_OFS, cmd(8'h05, apts_pkg::READ_POS_DNO));
    rd(apts_pkg::POSCMD_OFS, '1, 32'h0000_0F5A, "pos_fs");
    fault <= 1'b1;
    repeat (3) @(posedge clk);
    check("flt_son", {31'h0, servo_on_request}, 32'h0);
    check("flt_base", {31'h0, base_circuit_on}, 32'h0);
    check("flt_rdy", {31'h0, drive_ready}, 32'h0);
    check("comm_clr", {31'h0, comm_error}, 32'h0);
    fault <= 1'b0;
    repeat (2) @(posedge clk);
    check("alm_set", {31'h0, alarm_coil_a}, 32'h1);
    alarm_reset_cmd <= 1'b1;
    @(posedge clk);
    alarm_reset_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    check("alm_clr", {31'h0, alarm_coil_a}, 32'h0);
    sum_bad_cmd <= 1'b1;
    repeat (4) @(posedge clk);
    sum_bad_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    check("sum_err", {31'h0, checksum_error_coil_a}, 32'h1);
    servo_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    servo_cmd <= 1'b1;
    repeat (3) @(posedge clk);
    check("sum_clr", {31'h0, checksum_error_coil_a}, 32'h0);
    print_verdict();
  end
endmodule : apts_supervisor_bench
`default_nettype wire
